// >>> pmd_pkg.sv
// Constants and types shared by the program memory decoder
package pmd_pkg;
    // Register offsets on the control port
    localparam logic [7:0] PMD_SIZE_OFS = 8'hc2;
    localparam logic [7:0] PMD_UNLOCK_OFS = 8'hc7;
    // Size-limit field layout and reset value
    localparam int PMD_SIZE_LSB = 0;
    localparam int PMD_SIZE_W = 3;
    localparam logic [2:0] PMD_SIZE_RST = 3'h5;
    localparam logic [2:0] PMD_SIZE_MAXCODE = 3'h5;
    // Unlock key sequence and its window in cycles
    localparam logic [7:0] PMD_KEY_FIRST = 8'haa;
    localparam logic [7:0] PMD_KEY_SECOND = 8'h55;
    localparam logic [2:0] PMD_UNLOCK_CYC = 3'h4;
    // On-chip array geometry
    localparam int PMD_ROM_DEPTH = 16384;
    localparam int PMD_ROM_AW = 14;
    localparam logic [15:0] PMD_ROM_TOP = 16'h3fff;
    // Upper bounds (exclusive) of each size code
    localparam logic [16:0] PMD_LIM_0K = 17'h00000;
    localparam logic [16:0] PMD_LIM_1K = 17'h00400;
    localparam logic [16:0] PMD_LIM_2K = 17'h00800;
    localparam logic [16:0] PMD_LIM_4K = 17'h01000;
    localparam logic [16:0] PMD_LIM_8K = 17'h02000;
    localparam logic [16:0] PMD_LIM_16K = 17'h04000;
    // External fetch sequencer states, Gray along the path
    typedef enum logic [2:0] {
        PMD_IDLE = 3'h0,
        PMD_ADDR = 3'h1,
        PMD_HOLD = 3'h3,
        PMD_STRB = 3'h2,
        PMD_WAIT = 3'h6,
        PMD_SAMP = 3'h7
    } pmd_state_t;
endpackage : pmd_pkg

// >>> pmd_top.sv
// Program fetch decoder: on-chip array or external bus on ports 0 and 2
module pmd_top
    import pmd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core fetch request and answer
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic fetch_busy,
    output logic fetch_valid,
    output logic fetch_ext,
    output logic [7:0] fetch_data,
    // Array load port
    input wire logic rom_load_en,
    input wire logic [13:0] rom_load_addr,
    input wire logic [7:0] rom_load_data,
    // General I/O values from and to the core
    input wire logic [7:0] port_zero_gpio_out,
    input wire logic port_zero_gpio_oe,
    input wire logic [7:0] port_two_gpio_out,
    output logic [7:0] port_zero_gpio_in,
    // Pins
    input wire logic external_access_n,
    input wire logic [7:0] port_zero_in,
    output logic [7:0] port_zero_out,
    output logic port_zero_oe,
    output logic [7:0] port_two_out,
    output logic addr_latch_en,
    output logic program_store_strobe_n
);

    // Limit of the on-chip region for a size code
    function automatic logic [16:0] pmd_limit(input logic [2:0] code);
        logic [16:0] lim;
        lim = PMD_LIM_0K;
        case (code)
            3'h1: lim = PMD_LIM_1K;
            3'h2: lim = PMD_LIM_2K;
            3'h3: lim = PMD_LIM_4K;
            3'h4: lim = PMD_LIM_8K;
            3'h5: lim = PMD_LIM_16K;
            default: lim = PMD_LIM_0K;
        endcase
        return lim;
    endfunction : pmd_limit

    // On-chip array, loaded through the load port
    logic [7:0] rom [0:PMD_ROM_DEPTH-1];

    logic [2:0] size_sel;
    logic [2:0] arm_cnt;
    logic [2:0] open_cnt;
    logic ea_meta;
    logic ea_sync;
    logic [7:0] p0_meta;
    logic [7:0] p0_sync;
    logic [15:0] ext_addr;
    pmd_state_t state;
    pmd_state_t next_state;

    // Register decode
    wire sel_size = reg_addr == PMD_SIZE_OFS;
    wire sel_unlock = reg_addr == PMD_UNLOCK_OFS;
    wire key_first = reg_wr && sel_unlock && reg_wdata == PMD_KEY_FIRST;
    wire key_second = reg_wr && sel_unlock && reg_wdata == PMD_KEY_SECOND
        && arm_cnt != 3'h0;
    wire [2:0] wr_code = reg_wdata[PMD_SIZE_LSB +: PMD_SIZE_W];
    wire size_wr = reg_wr && sel_size;
    // Only unlocked writes of a valid code are taken
    wire size_wr_ok = size_wr && open_cnt != 3'h0
        && wr_code <= PMD_SIZE_MAXCODE;
    wire [7:0] rd_value = sel_size ? {5'h00, size_sel} : 8'h00;

    // Fetch decode on the live limit; only array or bus are targets
    wire [16:0] cur_limit = pmd_limit(size_sel);
    wire below_limit = {1'b0, fetch_addr} < cur_limit;
    wire in_array = fetch_addr <= PMD_ROM_TOP;
    wire go_internal = below_limit && in_array && ea_sync;
    wire take = fetch_req && state == PMD_IDLE;
    wire take_int = take && go_internal;
    wire take_ext = take && !go_internal;
    wire [7:0] rom_word = rom[fetch_addr[PMD_ROM_AW-1:0]];

    // Array load
    always_ff @(posedge sys_clk)
    begin
        if (rom_load_en)
            rom[rom_load_addr] <= rom_load_data;
    end

    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ea_meta <= 1'b1;
            ea_sync <= 1'b1;
            p0_meta <= 8'h00;
            p0_sync <= 8'h00;
        end
        else
        begin
            ea_meta <= external_access_n;
            ea_sync <= ea_meta;
            p0_meta <= port_zero_in;
            p0_sync <= p0_meta;
        end
    end

    // Size register and read data
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            size_sel <= PMD_SIZE_RST;
            reg_rdata <= 8'h00;
        end
        else
        begin
            if (size_wr_ok)
                size_sel <= wr_code;
            reg_rdata <= reg_rd ? rd_value : 8'h00;
        end
    end

    // Unlock sequence counters
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arm_cnt <= 3'h0;
            open_cnt <= 3'h0;
        end
        else
        begin
            if (key_first)
                arm_cnt <= PMD_UNLOCK_CYC;
            else if (arm_cnt != 3'h0)
                arm_cnt <= arm_cnt - 3'h1;
            if (key_second)
                open_cnt <= PMD_UNLOCK_CYC;
            else if (size_wr)
                open_cnt <= 3'h0;
            else if (open_cnt != 3'h0)
                open_cnt <= open_cnt - 3'h1;
        end
    end

    // External fetch sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            PMD_IDLE: next_state = take_ext ? PMD_ADDR : PMD_IDLE;
            PMD_ADDR: next_state = PMD_HOLD;
            PMD_HOLD: next_state = PMD_STRB;
            PMD_STRB: next_state = PMD_WAIT;
            PMD_WAIT: next_state = PMD_SAMP;
            PMD_SAMP: next_state = PMD_IDLE;
            default: next_state = PMD_IDLE;
        endcase
    end

    // Sequencer state and captured address
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= PMD_IDLE;
            ext_addr <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            if (take_ext)
                ext_addr <= fetch_addr;
        end
    end

    // Bus pin timing, registered from the next state
    wire bus_next = next_state != PMD_IDLE;
    wire addr_phase = next_state == PMD_ADDR || next_state == PMD_HOLD;
    wire strobe_phase = next_state == PMD_STRB || next_state == PMD_WAIT
        || next_state == PMD_SAMP;
    wire [15:0] bus_addr = take_ext ? fetch_addr : ext_addr;

    // Port and strobe outputs
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_zero_out <= 8'h00;
            port_zero_oe <= 1'b0;
            port_two_out <= 8'h00;
            addr_latch_en <= 1'b0;
            program_store_strobe_n <= 1'b1;
            port_zero_gpio_in <= 8'h00;
        end
        else
        begin
            // Bus owns the ports while a fetch runs
            port_zero_out <= addr_phase ? bus_addr[7:0]
                : (bus_next ? 8'h00 : port_zero_gpio_out);
            port_zero_oe <= addr_phase
                || (!bus_next && port_zero_gpio_oe);
            port_two_out <= bus_next ? bus_addr[15:8]
                : port_two_gpio_out;
            addr_latch_en <= next_state == PMD_ADDR;
            program_store_strobe_n <= !strobe_phase;
            port_zero_gpio_in <= bus_next ? port_zero_gpio_in : p0_sync;
        end
    end

    // Fetch answer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fetch_busy <= 1'b0;
            fetch_valid <= 1'b0;
            fetch_ext <= 1'b0;
            fetch_data <= 8'h00;
        end
        else
        begin
            fetch_busy <= bus_next;
            fetch_valid <= take_int || state == PMD_SAMP;
            if (take_int)
            begin
                fetch_data <= rom_word;
                fetch_ext <= 1'b0;
            end
            else if (state == PMD_SAMP)
            begin
                fetch_data <= p0_sync;
                fetch_ext <= 1'b1;
            end
        end
    end

    // Locked writes leave the size untouched
    property p_locked;
        @(posedge sys_clk) disable iff (!rst_n)
        (size_wr && open_cnt == 3'h0) |=> $stable(size_sel);
    endproperty
    a_locked: assert property (p_locked)
        else $error("size changed without unlock");

    // Unlocked valid write lands next cycle
    property p_apply;
        @(posedge sys_clk) disable iff (!rst_n)
        size_wr_ok |=> size_sel == $past(wr_code);
    endproperty
    a_apply: assert property (p_apply)
        else $error("accepted size write not applied");

    // Read back shows the field with zero upper bits
    property p_readback;
        @(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && sel_size) |=> reg_rdata == {5'h00, $past(size_sel)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("size readback wrong");

    // Low access pin always starts a bus fetch
    property p_ea_force;
        @(posedge sys_clk) disable iff (!rst_n)
        (take && !ea_sync) |=> state == PMD_ADDR && addr_latch_en;
    endproperty
    a_ea_force: assert property (p_ea_force)
        else $error("fetch stayed on-chip with access pin low");

    // Zero size sends everything off-chip
    property p_zero_size;
        @(posedge sys_clk) disable iff (!rst_n)
        (take && size_sel == 3'h0) |=> fetch_busy ##5 fetch_valid && fetch_ext;
    endproperty
    a_zero_size: assert property (p_zero_size)
        else $error("zero size fetch not external");

    // 1k code: address 0400h goes outside
    property p_code_1k;
        @(posedge sys_clk) disable iff (!rst_n)
        (take && size_sel == 3'h1 && fetch_addr == 16'h0400) |=> !fetch_valid;
    endproperty
    a_code_1k: assert property (p_code_1k)
        else $error("1k limit decoded wrong");

    // On-chip hit answers next cycle from the array
    property p_internal;
        @(posedge sys_clk) disable iff (!rst_n)
        take_int |=> fetch_valid && !fetch_ext && program_store_strobe_n;
    endproperty
    a_internal: assert property (p_internal)
        else $error("on-chip fetch not answered");

    // Above the limit the strobe falls three cycles on
    property p_strobe;
        @(posedge sys_clk) disable iff (!rst_n)
        take_ext |=> program_store_strobe_n [*2] ##1
            !program_store_strobe_n [*3] ##1 program_store_strobe_n;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("program strobe timing wrong");

    // High address on port two throughout the bus fetch
    property p_port_two;
        @(posedge sys_clk) disable iff (!rst_n)
        fetch_busy |-> port_two_out == ext_addr[15:8];
    endproperty
    a_port_two: assert property (p_port_two)
        else $error("port two not carrying address");

    // Port 0 is released while the memory drives it
    property p_release;
        @(posedge sys_clk) disable iff (!rst_n)
        !program_store_strobe_n |-> !port_zero_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("port zero driven during strobe");

endmodule : pmd_top

// >>> pmd_ext_rom.sv
// External program ROM model answering on the multiplexed port 0 bus
module pmd_ext_rom (
    // Clock
    input wire logic sys_clk,
    // Bus from the decoder
    input wire logic [7:0] port_zero_out,
    input wire logic port_zero_oe,
    input wire logic [7:0] port_two_out,
    input wire logic addr_latch_en,
    input wire logic program_store_strobe_n,
    // Resolved port 0 pin level
    output logic [7:0] port_zero_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lat_addr;
    logic [7:0] last;
    logic [7:0] rom_q;
    // Address latch, last byte kept for the released bus
    always_ff @(posedge sys_clk)
    begin
        if (addr_latch_en)
            lat_addr <= {port_two_out, port_zero_out};
        if (!program_store_strobe_n)
            last <= rom_q;
    end
    // Contents; released bus shows inverted last byte
    assign rom_q = lat_addr[7:0] ^ lat_addr[15:8] ^ 8'hc3;
    assign port_zero_in = port_zero_oe ? port_zero_out
        : (!program_store_strobe_n ? rom_q : ~last);
endmodule : pmd_ext_rom

// >>> tb_program_memory_decode.sv
// Self-checking bench for the program memory decoder
module tb_program_memory_decode
    import pmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fetch_req = 1'b0;
    logic [15:0] fetch_addr = 16'h0000;
    logic rom_load_en = 1'b0;
    logic [13:0] rom_load_addr = 14'h0000;
    logic [7:0] rom_load_data = 8'h00;
    logic [7:0] port_zero_gpio_out = 8'h69;
    logic port_zero_gpio_oe = 1'b1;
    logic [7:0] port_two_gpio_out = 8'h96;
    logic external_access_n = 1'b1;
    logic [7:0] reg_rdata, fetch_data, port_zero_gpio_in, port_zero_in;
    logic [7:0] port_zero_out, port_two_out;
    logic fetch_busy, fetch_valid, fetch_ext, port_zero_oe;
    logic addr_latch_en, program_store_strobe_n;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;

    pmd_top pmd_top_i (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .fetch_req, .fetch_addr, .fetch_busy,
        .fetch_valid, .fetch_ext, .fetch_data, .rom_load_en, .rom_load_addr,
        .rom_load_data, .port_zero_gpio_out, .port_zero_gpio_oe,
        .port_two_gpio_out, .port_zero_gpio_in, .external_access_n,
        .port_zero_in, .port_zero_out, .port_zero_oe, .port_two_out,
        .addr_latch_en, .program_store_strobe_n);
    pmd_ext_rom pmd_ext_rom_i (.sys_clk, .port_zero_out, .port_zero_oe,
        .port_two_out, .addr_latch_en, .program_store_strobe_n,
        .port_zero_in);

    // Clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            bad_count++;
            conclude();
        end
    end

    task automatic conclude();
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rdc

    // Unlock then write the size code with upper bits set
    task automatic ssz(input logic [2:0] c);
        wr(PMD_UNLOCK_OFS, PMD_KEY_FIRST);
        wr(PMD_UNLOCK_OFS, PMD_KEY_SECOND);
        wr(PMD_SIZE_OFS, {5'h1f, c});
    endtask : ssz

    // One fetch, judging route, data, strobe width and ports
    task automatic fe(input logic [15:0] a, input logic ext);
        int pl;
        logic [7:0] exp;
        pl = 0;
        exp = ext ? (a[7:0] ^ a[15:8] ^ 8'hc3)
            : (a[7:0] ^ {2'h0, a[13:8]} ^ 8'h3c);
        @(posedge sys_clk);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        @(posedge sys_clk);
        fetch_req <= 1'b0;
        repeat (10)
        begin
            #1;
            if (fetch_valid === 1'b1)
                break;
            if (program_store_strobe_n === 1'b0)
            begin
                pl++;
                chk(port_zero_oe, 1'b0);
            end
            if (addr_latch_en === 1'b1)
            begin
                chk({port_two_out, port_zero_out}, a);
                chk(port_zero_oe, 1'b1);
                chk(fetch_busy, 1'b1);
            end
            @(posedge sys_clk);
        end
        chk(fetch_valid, 1'b1);
        chk(fetch_ext, ext);
        chk(fetch_data, exp);
        chk(16'(pl), ext ? 16'h3 : 16'h0);
        chk(fetch_busy, 1'b0);
        @(posedge sys_clk);
        #1;
        chk(port_two_out, port_two_gpio_out);
        chk(port_zero_out, port_zero_gpio_out);
        chk(port_zero_oe, port_zero_gpio_oe);
    endtask : fe

    task automatic t_reset();
        chk(port_zero_gpio_in, port_zero_gpio_out);
        rdc(PMD_SIZE_OFS, 8'h05);
        rdc(8'hc0, 8'h00);
        fe(16'h0000, 1'b0);
        fe(16'h3fff, 1'b0);
        fe(16'h4000, 1'b1);
    endtask : t_reset

    task automatic t_lock();
        wr(PMD_SIZE_OFS, 8'h01);
        rdc(PMD_SIZE_OFS, 8'h05);
        wr(PMD_UNLOCK_OFS, PMD_KEY_FIRST);
        wr(PMD_SIZE_OFS, 8'h01);
        rdc(PMD_SIZE_OFS, 8'h05);
        fe(16'h0400, 1'b0);
    endtask : t_lock

    task automatic t_sizes();
        logic [16:0] lim [6];
        lim = '{PMD_LIM_0K, PMD_LIM_1K, PMD_LIM_2K, PMD_LIM_4K,
            PMD_LIM_8K, PMD_LIM_16K};
        for (int c = 0; c < 6; c++)
        begin
            ssz(3'(c));
            rdc(PMD_SIZE_OFS, 8'(c));
            fe(16'(lim[c]), 1'b1);
            if (c > 0)
                fe(16'(lim[c] - 17'h1), 1'b0);
        end
    endtask : t_sizes

    task automatic t_reserved();
        ssz(3'h6);
        rdc(PMD_SIZE_OFS, 8'h05);
        ssz(3'h7);
        rdc(PMD_SIZE_OFS, 8'h05);
    endtask : t_reserved

    task automatic t_force();
        @(posedge sys_clk);
        external_access_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        fe(16'h0000, 1'b1);
        @(posedge sys_clk);
        external_access_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        fe(16'h0000, 1'b0);
    endtask : t_force

    // Reset in mid-run brings back the full on-chip size
    task automatic t_rerst();
        ssz(3'h2);
        rdc(PMD_SIZE_OFS, 8'h02);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(PMD_SIZE_OFS, 8'h05);
        fe(16'h3fff, 1'b0);
    endtask : t_rerst

    // Main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        chk(program_store_strobe_n, 1'b1);
        rst_n <= 1'b1;
        for (int a = 0; a < PMD_ROM_DEPTH; a++)
        begin
            @(posedge sys_clk);
            rom_load_en <= 1'b1;
            rom_load_addr <= 14'(a);
            rom_load_data <= 8'(a) ^ 8'(a >> 8) ^ 8'h3c;
        end
        @(posedge sys_clk);
        rom_load_en <= 1'b0;
        t_reset();
        t_lock();
        t_sizes();
        t_reserved();
        t_force();
        t_rerst();
        conclude();
    end
endmodule : tb_program_memory_decode
